/* File: edge_interrupt_led_toggle.sv */
// Edge interrupt with LED toggling counter, AHB-Lite register slave
`default_nettype none

module edge_interrupt_led_toggle (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        nmi_n,
	output logic             led_output_pin,
	output logic             led_output_pin_oe,
	output logic             irq
);
	import edge_led_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic                   access;
	reg_id_t                addr_sel;
	logic                   wr_pend;
	reg_id_t                wr_sel;
	logic                   next_wr_pend;
	reg_id_t                next_wr_sel;
	logic [31:0]            next_hrdata;

	logic [7:0]             port_seven_data;
	logic [7:0]             port_seven_direction;
	logic [7:0]             interrupt_edge_select;
	logic [7:0]             user_flag_byte;
	logic [1:0]             int_status;
	logic [1:0]             int_mask;
	logic [7:0]             next_port_data;
	logic [7:0]             next_port_dir;
	logic [7:0]             next_edge_sel;
	logic [7:0]             next_user_flag;
	logic [1:0]             next_status;
	logic [1:0]             next_mask;

	logic [COUNT_W-1:0]     counter;
	logic [COUNT_W-1:0]     next_counter;
	logic                   switch_on_flag;
	logic                   wrap;
	logic                   nmi_request;
	logic [1:0]             events;

	nmi_edge_if edge_link ();

	////////////////////////////////////////////////////////////////////////
	// Address decode, shared by read and write paths
	function automatic reg_id_t reg_decode(input logic [31:0] addr);
		reg_id_t id;
		id = REG_NONE;
		if (addr == ADDR_PORT_DATA) begin
			id = REG_PORT_DATA;
		end else if (addr == ADDR_PORT_DIR) begin
			id = REG_PORT_DIR;
		end else if (addr == ADDR_EDGE_SEL) begin
			id = REG_EDGE_SEL;
		end else if (addr == ADDR_INT_STATUS) begin
			id = REG_INT_STATUS;
		end else if (addr == ADDR_INT_MASK) begin
			id = REG_INT_MASK;
		end else if (addr == ADDR_USER_FLAG) begin
			id = REG_USER_FLAG;
		end else if (addr == ADDR_COUNTER) begin
			id = REG_COUNTER;
		end
		return id;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Edge detector on the interrupt pin
	assign edge_link.pin_level = nmi_n;
	assign edge_link.rising_sel = interrupt_edge_select[NMI_EDGE_BIT];
	assign nmi_request = edge_link.request;

	nmi_edge_detect nmi_edge_detect_inst (
		.hclk    (hclk),
		.hresetn (hresetn),
		.port    (edge_link.detector)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus slave: address phase capture and read data
	assign access   = hsel & htrans[1] & hready;
	assign addr_sel = reg_decode(haddr);

	always_comb begin
		next_wr_pend = access & hwrite;
		next_wr_sel  = access ? addr_sel : REG_NONE;
		next_hrdata  = 32'h0000_0000;
		if (access && !hwrite) begin
			case (addr_sel)
				REG_PORT_DATA:  next_hrdata[7:0] = port_seven_data;
				REG_PORT_DIR:   next_hrdata[7:0] = port_seven_direction;
				REG_EDGE_SEL:   next_hrdata[7:0] = interrupt_edge_select;
				REG_INT_STATUS: next_hrdata[1:0] = int_status;
				REG_INT_MASK:   next_hrdata[1:0] = int_mask;
				REG_USER_FLAG:  next_hrdata[7:0] = user_flag_byte;
				REG_COUNTER:    next_hrdata[15:0] = counter;
				default:        next_hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Zero wait states; every answer is OKAY, unmapped reads return zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_sel    <= REG_NONE;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend   <= next_wr_pend;
			wr_sel    <= next_wr_sel;
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter runs while the switch-on flag is set
	assign switch_on_flag = user_flag_byte[SW_FLAG_BIT];
	assign wrap           = switch_on_flag && (counter == COUNT_MAX);

	always_comb begin
		next_counter = counter;
		if (switch_on_flag) begin
			next_counter = counter + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter <= COUNT_RST;
		end else begin
			counter <= next_counter;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers: software writes first, hardware events on top
	always_comb begin
		events                      = 2'h0;
		events[EV_NMI_BIT]          = nmi_request;
		events[EV_WRAP_BIT]         = wrap;
		next_port_data              = port_seven_data;
		next_port_dir               = port_seven_direction;
		next_edge_sel               = interrupt_edge_select;
		next_user_flag              = user_flag_byte;
		next_status                 = int_status;
		next_mask                   = int_mask;
		if (wr_pend) begin
			case (wr_sel)
				REG_PORT_DATA:  next_port_data = hwdata[7:0];
				REG_PORT_DIR:   next_port_dir = hwdata[7:0];
				REG_EDGE_SEL:   next_edge_sel = hwdata[7:0];
				REG_INT_STATUS: next_status = int_status & ~hwdata[1:0];
				REG_INT_MASK:   next_mask = hwdata[1:0];
				REG_USER_FLAG:  next_user_flag = hwdata[7:0];
				default:        next_mask = int_mask;
			endcase
		end
		if (wrap) begin
			next_port_data[LED_BIT] = ~next_port_data[LED_BIT];
			next_user_flag[LED_FLAG_BIT] = ~next_user_flag[LED_FLAG_BIT];
		end
		if (nmi_request) begin
			next_user_flag[SW_FLAG_BIT] = 1'b1;
		end
		// taken regardless of mask
		// Sticky events; a set beats a same-cycle clear
		next_status = next_status | events;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_seven_data       <= RST_PORT_DATA;
			port_seven_direction  <= RST_PORT_DIR;
			interrupt_edge_select <= RST_EDGE_SEL;
			user_flag_byte        <= RST_USER_FLAG;
			int_status            <= RST_STATUS;
			int_mask              <= RST_MASK;
		end else begin
			port_seven_data       <= next_port_data;
			port_seven_direction  <= next_port_dir;
			interrupt_edge_select <= next_edge_sel;
			user_flag_byte        <= next_user_flag;
			int_status            <= next_status;
			int_mask              <= next_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin and interrupt outputs, registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			led_output_pin    <= 1'b0;
			led_output_pin_oe <= 1'b0;
			irq               <= 1'b0;
		end else begin
			led_output_pin    <= next_port_data[LED_BIT]
				& next_port_dir[LED_BIT];
			led_output_pin_oe <= next_port_dir[LED_BIT];
			irq               <= |(next_status & next_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_switch_flag_set: assert property (
		nmi_request |=> switch_on_flag)
		else $error("switch-on flag not set by interrupt");
	a_nmi_ignores_mask: assert property (
		nmi_request |=> int_status[EV_NMI_BIT])
		else $error("interrupt not taken while masked");
	a_count_step: assert property (
		switch_on_flag |=> counter == $past(counter) + 16'h0001)
		else $error("counter did not step");
	a_count_idle: assert property (
		!switch_on_flag ##1 !switch_on_flag |-> $stable(counter))
		else $error("counter moved without switch-on flag");
	a_wrap_toggle: assert property (
		(wrap && !(wr_pend && wr_sel == REG_PORT_DATA)
			&& port_seven_direction[LED_BIT]
			&& !(wr_pend && wr_sel == REG_PORT_DIR))
		|=> led_output_pin != $past(led_output_pin))
		else $error("LED not inverted on wrap");
	a_led_flag_toggle: assert property (
		(wrap && !(wr_pend && wr_sel == REG_USER_FLAG))
		|=> user_flag_byte[LED_FLAG_BIT]
			!= $past(user_flag_byte[LED_FLAG_BIT]))
		else $error("LED-on flag not inverted on wrap");
	a_pin_level: assert property (
		(wr_pend && wr_sel == REG_PORT_DATA && !wrap
			&& port_seven_direction[LED_BIT])
		|=> led_output_pin == $past(hwdata[LED_BIT]))
		else $error("LED pin does not follow data bit");
	a_pin_direction: assert property (
		(wr_pend && wr_sel == REG_PORT_DIR)
		|=> led_output_pin_oe == $past(hwdata[LED_BIT]))
		else $error("LED pin enable does not follow direction bit");
	a_edge_select: assert property (
		(wr_pend && wr_sel == REG_EDGE_SEL)
		|=> edge_link.rising_sel == $past(hwdata[NMI_EDGE_BIT]))
		else $error("edge selector not taken from bit 7");
	a_irq_level: assert property (
		irq == (|(int_status & int_mask)))
		else $error("interrupt output differs from unmasked status");
	a_wrap_restart: assert property (
		wrap |=> counter == COUNT_RST)
		else $error("counter did not restart after wrap");
	a_wrap_event: assert property (
		wrap |=> int_status[EV_WRAP_BIT])
		else $error("wrap event not recorded");
	a_nmi_sticky: assert property (
		(int_status[EV_NMI_BIT] && !(wr_pend && wr_sel == REG_INT_STATUS))
		|=> int_status[EV_NMI_BIT])
		else $error("interrupt taken flag lost without a clear");
	a_led_level: assert property (
		$past(hresetn) |-> led_output_pin
			== (port_seven_data[LED_BIT] & port_seven_direction[LED_BIT]))
		else $error("LED pin differs from data and direction bits");
	a_led_enable: assert property (
		$past(hresetn) |-> led_output_pin_oe
			== port_seven_direction[LED_BIT])
		else $error("LED pin enable differs from direction bit");
	a_bus_okay: assert property (
		hreadyout && !hresp)
		else $error("bus answer not ready and okay");

	c_nmi_taken: cover property (nmi_request);
	c_counter_wrap: cover property (wrap ##1 led_output_pin);
	c_irq_raised: cover property (!irq ##1 irq);
	c_rising_edge: cover property (edge_link.rising_sel && nmi_request);
	c_masked_irq: cover property (irq && int_mask[EV_WRAP_BIT]);
endmodule

`default_nettype wire

/* File: edge_interrupt_led_toggle_bench.sv */
// Self-checking bench for the edge interrupt and LED toggle block
`default_nettype none

module edge_interrupt_led_toggle_bench;
	import edge_led_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        nmi_n;
	logic        led_output_pin;
	logic        led_output_pin_oe;
	logic        irq;
	logic        pressed;
	logic        led_lit;
	logic [31:0] rd;
	logic [31:0] c1;
	int          miscompares;
	int          checks_done;
	int          i;

	////////////////////////////////////////////////////////////////////////
	// Design, far side and clock
	assign hready = hreadyout;  // Single slave drives the bus ready

	edge_interrupt_led_toggle edge_interrupt_led_toggle_inst (
		.hclk              (hclk),
		.hresetn           (hresetn),
		.hsel              (hsel),
		.haddr             (haddr),
		.htrans            (htrans),
		.hwrite            (hwrite),
		.hsize             (hsize),
		.hwdata            (hwdata),
		.hready            (hready),
		.hrdata            (hrdata),
		.hreadyout         (hreadyout),
		.hresp             (hresp),
		.nmi_n             (nmi_n),
		.led_output_pin    (led_output_pin),
		.led_output_pin_oe (led_output_pin_oe),
		.irq               (irq)
	);

	switch_led_model switch_led_model_inst (
		.pressed           (pressed),
		.nmi_n             (nmi_n),
		.led_output_pin    (led_output_pin),
		.led_output_pin_oe (led_output_pin_oe),
		.led_lit           (led_lit)
	);

	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end

	////////////////////////////////////////////////////////////////////////
	// Bus tasks: address phase held until ready, then data phase
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic addr_phase(input logic [31:0] a, input logic w);
		@(posedge hclk);
		hsel   <= 1'h1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'h1) @(posedge hclk);
		htrans <= 2'h0;
		hsel   <= 1'h0;
	endtask

	task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
		addr_phase(a, 1'h1);
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'h1) @(posedge hclk);
	endtask

	task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
		addr_phase(a, 1'h0);
		@(posedge hclk);
		while (hready !== 1'h1) @(posedge hclk);
		d = hrdata;  // Value before this edge's updates land
	endtask

	////////////////////////////////////////////////////////////////////////
	// Comparisons and verdict
	task automatic check_reg(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask

	task automatic check_pin(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %b, seen %b", n, e, g);
		end
	endtask

	task automatic read_check(input string n, input logic [31:0] a,
		input logic [31:0] e);
		logic [31:0] d;
		bus_read(a, d);
		check_reg(n, e, d);
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog: one LED wrap plus setup stays well under this span
	initial begin
		#900000;
		miscompares++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		hresetn     = 1'h0;
		hsel        = 1'h0;
		haddr       = 32'h0000_0000;
		htrans      = 2'h0;
		hwrite      = 1'h0;
		hsize       = 3'h2;
		hwdata      = 32'h0000_0000;
		pressed     = 1'h0;
		miscompares = 0;
		checks_done = 0;
		tick(3);
		hresetn <= 1'h1;
		tick(2);
		// Values after reset
		check_pin("led pin enable", 1'h1, led_output_pin_oe);
		check_pin("led pin", 1'h0, led_output_pin);
		read_check("port data", ADDR_PORT_DATA, 32'h0000_0000);
		read_check("port direction", ADDR_PORT_DIR, 32'h0000_0010);
		read_check("edge select", ADDR_EDGE_SEL, 32'h0000_0000);
		read_check("user flags", ADDR_USER_FLAG, 32'h0000_0000);
		read_check("counter", ADDR_COUNTER, 32'h0000_0000);
		// Unmapped place reads zero and drops writes
		bus_write(32'h0000_0200, 32'hFFFF_FFFF);
		read_check("unmapped", 32'h0000_0200, 32'h0000_0000);
		check_pin("bus ready", 1'h1, hreadyout);
		check_pin("okay response", 1'h0, hresp);
		// Port data and direction steer the pin
		bus_write(ADDR_PORT_DATA, 32'h0000_0010);
		tick(2);
		check_pin("led pin", 1'h1, led_output_pin);
		check_pin("led lit", 1'h1, led_lit);
		bus_write(ADDR_PORT_DIR, 32'h0000_0000);
		tick(2);
		check_pin("led pin enable", 1'h0, led_output_pin_oe);
		bus_write(ADDR_PORT_DIR, 32'h0000_0010);
		bus_write(ADDR_PORT_DATA, 32'h0000_0000);
		tick(2);
		check_pin("led pin enable", 1'h1, led_output_pin_oe);
		check_pin("led pin", 1'h0, led_output_pin);
		// Rising edges chosen: press ignored, release taken, mask ignored
		bus_write(ADDR_EDGE_SEL, 32'h0000_0080);
		pressed <= 1'h1;
		tick(8);
		read_check("user flags", ADDR_USER_FLAG, 32'h0000_0000);
		pressed <= 1'h0;
		tick(8);
		read_check("user flags", ADDR_USER_FLAG, 32'h0000_0001);
		read_check("status", ADDR_INT_STATUS, 32'h0000_0001);
		check_pin("irq", 1'h0, irq);
		// Stop counting, clear events, back to falling edges, mask in
		bus_write(ADDR_USER_FLAG, 32'h0000_0000);
		bus_write(ADDR_INT_STATUS, 32'h0000_0003);
		bus_write(ADDR_EDGE_SEL, 32'h0000_0000);
		bus_write(ADDR_INT_MASK, 32'h0000_0001);
		read_check("mask", ADDR_INT_MASK, 32'h0000_0001);
		check_pin("irq", 1'h0, irq);
		// Falling edge taken and raises the interrupt line
		pressed <= 1'h1;
		tick(8);
		check_pin("irq", 1'h1, irq);
		read_check("user flags", ADDR_USER_FLAG, 32'h0000_0001);
		// Held switch and its release give no further event
		bus_write(ADDR_INT_STATUS, 32'h0000_0001);
		tick(8);
		check_pin("irq", 1'h0, irq);
		pressed <= 1'h0;
		tick(8);
		read_check("status", ADDR_INT_STATUS, 32'h0000_0000);
		// Counter steps once a cycle; reads are three cycles apart
		bus_read(ADDR_COUNTER, c1);
		bus_read(ADDR_COUNTER, rd);
		check_reg("counter step", c1 + 32'h0000_0003, rd);
		// First wrap lights the LED and flags the event
		bus_write(ADDR_INT_MASK, 32'h0000_0002);
		check_pin("led lit", 1'h0, led_lit);
		for (i = 0; i < 70000 && led_lit !== 1'h1; i++) @(posedge hclk);
		check_pin("led lit", 1'h1, led_lit);
		read_check("port data", ADDR_PORT_DATA, 32'h0000_0010);
		read_check("user flags", ADDR_USER_FLAG, 32'h0000_0003);
		read_check("status", ADDR_INT_STATUS, 32'h0000_0002);
		check_pin("irq", 1'h1, irq);
		print_verdict();
	end
endmodule

`default_nettype wire

/* File: edge_led_pkg.sv */
// Constants and types shared by the edge interrupt and LED toggle block
`default_nettype none

package edge_led_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_PORT_DATA = 16'hFFDA;
	localparam logic [15:0] IDX_PORT_DIR  = 16'hFFEA;
	localparam logic [15:0] IDX_EDGE_SEL  = 16'hFFF2;

	localparam logic [31:0] ADDR_PORT_DATA  = {14'h0000, IDX_PORT_DATA, 2'h0};
	localparam logic [31:0] ADDR_PORT_DIR   = {14'h0000, IDX_PORT_DIR, 2'h0};
	localparam logic [31:0] ADDR_EDGE_SEL   = {14'h0000, IDX_EDGE_SEL, 2'h0};
	localparam logic [31:0] ADDR_INT_STATUS = 32'h0000_0100;
	localparam logic [31:0] ADDR_INT_MASK   = 32'h0000_0104;
	localparam logic [31:0] ADDR_USER_FLAG  = 32'h0000_0108;
	localparam logic [31:0] ADDR_COUNTER    = 32'h0000_010C;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int LED_BIT      = 4;  // Port data and direction bit
	localparam int NMI_EDGE_BIT = 7;  // Edge selector, 0 = falling
	localparam int SW_FLAG_BIT  = 0;  // Switch-on flag in user flag byte
	localparam int LED_FLAG_BIT = 1;  // LED-on flag in user flag byte
	localparam int EV_NMI_BIT   = 0;  // Status: interrupt taken
	localparam int EV_WRAP_BIT  = 1;  // Status: counter wrapped

	////////////////////////////////////////////////////////////////////////
	// Reset values, matching the initialization sequence
	localparam logic [7:0] RST_PORT_DATA = 8'h00;
	localparam logic [7:0] RST_PORT_DIR  = 8'h10;
	localparam logic [7:0] RST_EDGE_SEL  = 8'h00;
	localparam logic [7:0] RST_USER_FLAG = 8'h00;
	localparam logic [1:0] RST_STATUS    = 2'h0;
	localparam logic [1:0] RST_MASK      = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Counter
	localparam int          COUNT_W   = 16;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	// Register selected by a bus address
	typedef enum logic [2:0] {
		REG_NONE,
		REG_PORT_DATA,
		REG_PORT_DIR,
		REG_EDGE_SEL,
		REG_INT_STATUS,
		REG_INT_MASK,
		REG_USER_FLAG,
		REG_COUNTER
	} reg_id_t;

endpackage

`default_nettype wire

/* File: nmi_edge_detect.sv */
// Synchroniser and selectable edge detector for the interrupt pin
`default_nettype none

module nmi_edge_detect (
	input  wire logic  hclk,
	input  wire logic  hresetn,
	nmi_edge_if.detector port
);
	logic sync_first;
	logic sync_second;
	logic last_level;
	logic request;
	logic next_request;

	////////////////////////////////////////////////////////////////////////
	// Edge compare on synchronised samples only
	// falling by default
	always_comb begin
		if (port.rising_sel) begin
			next_request = sync_second & ~last_level;
		end else begin
			next_request = ~sync_second & last_level;
		end
	end

	// Pin idles high through its pull-up, so the sampling flops reset high
	// single pulse per edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_first  <= 1'b1;
			sync_second <= 1'b1;
			last_level  <= 1'b1;
			request     <= 1'b0;
		end else begin
			sync_first  <= port.pin_level;
			sync_second <= sync_first;
			last_level  <= sync_second;
			request     <= next_request;
		end
	end

	assign port.request = request;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_fall_detect: assert property (
		(!port.rising_sel && last_level && !sync_second) |=> request)
		else $error("falling edge gave no request");
	a_rise_detect: assert property (
		(port.rising_sel && !last_level && sync_second) |=> request)
		else $error("rising edge gave no request");
	a_single_pulse: assert property (
		request |=> !request)
		else $error("request lasted more than one cycle");
endmodule

`default_nettype wire

/* File: nmi_edge_if.sv */
// Link between the register block and the interrupt edge detector
`default_nettype none

interface nmi_edge_if;
	logic pin_level;   // Raw interrupt pin level, not yet synchronised
	logic rising_sel;  // 1 = rising edges, 0 = falling edges
	logic request;     // One-cycle request pulse

	modport detector (
		input  pin_level,
		input  rising_sel,
		output request
	);
	modport controller (
		output pin_level,
		output rising_sel,
		input  request
	);
endinterface

`default_nettype wire

/* File: switch_led_model.sv */
// Model of the push switch on the interrupt pin and the LED on the port pin
`default_nettype none

module switch_led_model (
	input  wire logic pressed,
	output logic      nmi_n,
	input  wire logic led_output_pin,
	input  wire logic led_output_pin_oe,
	output logic      led_lit
);
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////
	// Switch pulls the pin to ground; the pull-up holds it high when open
	assign nmi_n = !pressed;

	// LED lights only while the pin is driven and high
	assign led_lit = led_output_pin_oe & led_output_pin;
endmodule

`default_nettype wire
